// ### rtl/pfs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor #(
	parameter int CE_WIDTH = pfs_pkg::PFS_CE_WIDTH
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire pfs_pkg::pfs_cmp_t   cmp_in,
	input  wire logic                warn_enable,
	input  wire logic                int_ack,
	input  wire logic [CE_WIDTH-1:0] core_ce_n,
	input  wire logic                core_rw_n,
	output var  logic                int_req,
	output var  logic [7:0]          int_vector,
	output var  logic                core_reset,
	output var  logic [CE_WIDTH-1:0] mem_ce_n,
	output var  logic                mem_rw_n,
	output var  logic                backup_select,
	output var  logic                core_power_down,
	output var  pfs_pkg::pfs_state_t state
);
	if (CE_WIDTH < 1 || CE_WIDTH > 16) begin : g_bad_ce_width
		$error("CE_WIDTH out of range");
	end

	// One count past the synchroniser depth, so cmp_prev also holds a
	// real sample before any crossing is believed.
	localparam int SETTLE_W = $clog2(pfs_pkg::PFS_SYNC_STAGES + 2);

	pfs_pkg::pfs_cmp_t   cmp;
	pfs_pkg::pfs_cmp_t   cmp_prev;
	pfs_pkg::pfs_state_t next_state;
	logic                next_int_req;
	logic [7:0]          next_int_vector;
	logic                next_core_reset;
	logic [CE_WIDTH-1:0] next_mem_ce_n;
	logic                next_mem_rw_n;
	logic                next_backup_select;
	logic                next_core_power_down;
	logic                warn_fall;
	logic [SETTLE_W-1:0] settle_cnt;
	logic [SETTLE_W-1:0] next_settle_cnt;
	logic                settled;

	pfs_sync #(
		.WIDTH($bits(pfs_pkg::pfs_cmp_t))
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.async_in(cmp_in),
		.sync_out(cmp)
	);

	// The synchroniser leaves reset reading a healthy supply, which would
	// release the core for a few cycles even below the minimum. The core
	// is therefore held until real samples have arrived.
	assign settled = settle_cnt ==
		SETTLE_W'(pfs_pkg::PFS_SYNC_STAGES + 1);

	always_comb begin
		next_settle_cnt = settle_cnt;
		if (!settled)
			next_settle_cnt = settle_cnt + SETTLE_W'(1);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			settle_cnt <= '0;
		else
			settle_cnt <= next_settle_cnt;
	end

	// Edge detect reads only the synchronised copy, and only once settled,
	// so a supply already low at reset release is not taken as a crossing.
	assign warn_fall = settled && cmp.below_warn
		&& !cmp_prev.below_warn;

	always_comb begin
		next_state = pfs_pkg::PFS_RUN;
		if (cmp.below_backup)
			next_state = pfs_pkg::PFS_BACKUP;
		else if (cmp.below_min || !settled)
			next_state = pfs_pkg::PFS_RESET;
		else if (cmp.below_warn)
			next_state = pfs_pkg::PFS_WARN;

		// A new crossing wins over an acknowledge in the same cycle.
		next_int_req = int_req;
		if (int_ack)
			next_int_req = 1'b0;
		if (warn_fall && warn_enable && !cmp.below_min)
			next_int_req = 1'b1;
		if (cmp.below_min)
			next_int_req = 1'b0;
		next_int_vector = pfs_pkg::PFS_WARN_VECTOR;

		next_core_reset      = 1'b0;
		next_mem_ce_n        = core_ce_n;
		next_mem_rw_n        = core_rw_n;
		next_backup_select   = 1'b0;
		next_core_power_down = 1'b0;
		case (next_state)
			pfs_pkg::PFS_RUN, pfs_pkg::PFS_WARN: begin
				next_core_reset = 1'b0;
			end
			pfs_pkg::PFS_RESET: begin
				next_core_reset = 1'b1;
				next_mem_ce_n   = '1;
				next_mem_rw_n   = 1'b1;
			end
			pfs_pkg::PFS_BACKUP: begin
				next_core_reset      = 1'b1;
				next_mem_ce_n        = '1;
				next_mem_rw_n        = 1'b1;
				next_backup_select   = 1'b1;
				next_core_power_down = 1'b1;
			end
			default: begin
				next_core_reset = 1'b1;
				next_mem_ce_n   = '1;
				next_mem_rw_n   = 1'b1;
			end
		endcase
	end

	// Reset assumes the rail is unknown, so the core is held and strobes idle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state           <= pfs_pkg::PFS_RESET;
			cmp_prev        <= '0;
			int_req         <= 1'b0;
			int_vector      <= pfs_pkg::PFS_WARN_VECTOR;
			core_reset      <= 1'b1;
			mem_ce_n        <= '1;
			mem_rw_n        <= 1'b1;
			backup_select   <= 1'b0;
			core_power_down <= 1'b0;
		end else begin
			state           <= next_state;
			cmp_prev        <= cmp;
			int_req         <= next_int_req;
			int_vector      <= next_int_vector;
			core_reset      <= next_core_reset;
			mem_ce_n        <= next_mem_ce_n;
			mem_rw_n        <= next_mem_rw_n;
			backup_select   <= next_backup_select;
			core_power_down <= next_core_power_down;
		end
	end

	chk_warn_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
		warn_fall && warn_enable && !cmp.below_min |=> int_req
		&& int_vector == pfs_pkg::PFS_WARN_VECTOR)
		else $error("warning interrupt not raised");
	chk_warn_no_reset: assert property (@(posedge clk) disable iff (!rst_n)
		settled && cmp.below_warn && !cmp.below_min
		&& !cmp.below_backup |=> !core_reset)
		else $error("warning alone reset the core");
	chk_min_reset: assert property (@(posedge clk) disable iff (!rst_n)
		cmp.below_min |=> core_reset)
		else $error("reset not held below minimum");
	chk_resume_run: assert property (@(posedge clk) disable iff (!rst_n)
		settled && core_reset && !cmp.below_min && !cmp.below_backup
		|=> !core_reset)
		else $error("core did not resume");
	chk_strobes_idle: assert property (@(posedge clk) disable iff (!rst_n)
		core_reset |-> mem_ce_n == '1 && mem_rw_n)
		else $error("strobes active during reset");
	chk_backup_sel: assert property (@(posedge clk) disable iff (!rst_n)
		cmp.below_backup |=> backup_select && core_power_down)
		else $error("backup not selected");
	chk_backup_off: assert property (@(posedge clk) disable iff (!rst_n)
		!cmp.below_backup |=> !backup_select)
		else $error("backup cell loaded above threshold");
	chk_irq_once: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(int_req) |-> $past(warn_fall))
		else $error("interrupt without falling crossing");
	chk_power_down: assert property (@(posedge clk) disable iff (!rst_n)
		core_power_down |-> backup_select && core_reset)
		else $error("power down outside backup");

	chk_settle_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!settled |=> core_reset)
		else $error("core released before comparators settled");
	chk_ce_pass: assert property (@(posedge clk) disable iff (!rst_n)
		settled && !cmp.below_min && !cmp.below_backup
		|=> mem_ce_n == $past(core_ce_n))
		else $error("chip enables not passed through");
	chk_rw_pass: assert property (@(posedge clk) disable iff (!rst_n)
		settled && !cmp.below_min && !cmp.below_backup
		|=> mem_rw_n == $past(core_rw_n))
		else $error("read/write strobe not passed through");
	chk_min_strobes: assert property (@(posedge clk) disable iff (!rst_n)
		cmp.below_min |=> mem_ce_n == '1 && mem_rw_n)
		else $error("strobes active below minimum");

	chk_irq_hold: assert property (@(posedge clk) disable iff (!rst_n)
		int_req && !int_ack && !cmp.below_min |=> int_req)
		else $error("interrupt dropped without acknowledge");
	chk_irq_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
		int_ack && !(warn_fall && warn_enable) |=> !int_req)
		else $error("interrupt not cleared by acknowledge");
	chk_irq_min_clear: assert property (@(posedge clk) disable iff (!rst_n)
		cmp.below_min |=> !int_req)
		else $error("interrupt pending below minimum");
	chk_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		!int_req && !(warn_fall && warn_enable) |=> !int_req)
		else $error("interrupt without enabled crossing");

	chk_state_run: assert property (@(posedge clk) disable iff (!rst_n)
		settled && !cmp.below_warn && !cmp.below_min && !cmp.below_backup
		|=> state == pfs_pkg::PFS_RUN)
		else $error("not running with healthy supply");
	chk_state_warn: assert property (@(posedge clk) disable iff (!rst_n)
		settled && cmp.below_warn && !cmp.below_min && !cmp.below_backup
		|=> state == pfs_pkg::PFS_WARN)
		else $error("warning state not entered");
	chk_state_reset: assert property (@(posedge clk) disable iff (!rst_n)
		cmp.below_min && !cmp.below_backup
		|=> state == pfs_pkg::PFS_RESET)
		else $error("reset state not entered");
	chk_state_backup: assert property (@(posedge clk) disable iff (!rst_n)
		cmp.below_backup |=> state == pfs_pkg::PFS_BACKUP)
		else $error("backup state not entered");
	chk_power_up: assert property (@(posedge clk) disable iff (!rst_n)
		!cmp.below_backup |=> !core_power_down)
		else $error("circuits left disabled above switchover");
	chk_run_clean: assert property (@(posedge clk) disable iff (!rst_n)
		state == pfs_pkg::PFS_RUN |-> !core_reset && !core_power_down)
		else $error("core held while running");
	chk_warn_runs: assert property (@(posedge clk) disable iff (!rst_n)
		state == pfs_pkg::PFS_WARN |-> !core_reset && !backup_select)
		else $error("warning state stopped the core");
	chk_backup_hold: assert property (@(posedge clk) disable iff (!rst_n)
		backup_select |-> core_reset && mem_ce_n == '1 && mem_rw_n)
		else $error("backup selected with core active");

	cov_warn: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(int_req));
	cov_reset: cover property (@(posedge clk) disable iff (!rst_n)
		state == pfs_pkg::PFS_RESET ##1 state == pfs_pkg::PFS_RUN);
	cov_backup: cover property (@(posedge clk) disable iff (!rst_n)
		state == pfs_pkg::PFS_BACKUP);
	cov_irq_ack: cover property (@(posedge clk) disable iff (!rst_n)
		int_req && int_ack ##1 !int_req);
	cov_settle: cover property (@(posedge clk) disable iff (!rst_n)
		!settled ##1 settled);
endmodule
`default_nettype wire

// ### rtl/pfs_pkg.sv
// Contract
// - Below the early-warning threshold with the warning enabled, request a vectored interrupt at handler address 2Bh; raised here only on a falling crossing.
// - Between the early-warning and minimum thresholds the processor keeps running; the warning alone never stops or resets it.
// - At the minimum operating threshold the device enters its internal reset state while the main rail still powers it.
// - Execution stays halted below the minimum threshold and resumes only once the supply is back above it.
// - In the power-fail reset state every decoded chip enable and the read/write strobe are driven to inactive logic 1.
// - Below the backup switchover threshold the backup cell is selected and feeds the external-memory supply output.
// - On the backup cell most internal circuits are disabled and nonvolatile state is preserved.
// - The backup cell is loaded only while the supply is below the switchover threshold.
package pfs_pkg;
	localparam logic [7:0] PFS_WARN_VECTOR = 8'h2b;
	localparam int         PFS_SYNC_STAGES = 2;
	localparam int         PFS_CE_WIDTH    = 4;

	typedef struct packed {
		logic below_warn;
		logic below_min;
		logic below_backup;
	} pfs_cmp_t;

	typedef enum logic [1:0] {
		PFS_RUN,
		PFS_WARN,
		PFS_RESET,
		PFS_BACKUP
	} pfs_state_t;
endpackage

// ### rtl/pfs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	// The first stage feeds only the second.
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_meta     = async_in;
		next_sync_out = meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= next_meta;
			sync_out <= next_sync_out;
		end
	end
endmodule
`default_nettype wire

// ### testbench/pfs_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_partner (
	input  wire logic              clk,
	input  wire logic [1:0]        level,
	input  wire logic              ack_en,
	input  wire logic              int_req,
	output var  pfs_pkg::pfs_cmp_t cmp_in,
	output var  logic              int_ack
);
	// Thresholds nest, so a lower supply trips every higher comparator.
	always_comb begin
		cmp_in.below_warn   = level >= 2'h1;
		cmp_in.below_min    = level >= 2'h2;
		cmp_in.below_backup = level == 2'h3;
	end
	initial int_ack = 1'b0;
	always @(negedge clk) begin
		int_ack <= ack_en && int_req && !int_ack;
	end
endmodule
`default_nettype wire

// ### testbench/tb_pfs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pfs_supervisor;
	logic                clk = 0, rst_n = 0, warn_enable = 0, core_rw_n = 1;
	logic                ack_en = 0, int_ack, int_req, core_reset, mem_rw_n;
	logic                backup_select, core_power_down;
	logic [1:0]          level = 2'h0;
	logic [3:0]          core_ce_n = 4'hf, mem_ce_n;
	logic [7:0]          int_vector;
	pfs_pkg::pfs_cmp_t   cmp_in;
	pfs_pkg::pfs_state_t state;
	int                  bad_count = 0, n_tests = 0, seed = 72180;
	pfs_supervisor u_pfs_supervisor (.clk, .rst_n, .cmp_in, .warn_enable,
		.int_ack, .core_ce_n, .core_rw_n, .int_req, .int_vector, .core_reset,
		.mem_ce_n, .mem_rw_n, .backup_select, .core_power_down, .state);
	pfs_partner u_pfs_partner (.clk, .level, .ack_en, .int_req, .cmp_in,
		.int_ack);
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic go(int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic [3:0] exp_ce(logic [1:0] l, logic [3:0] c);
		return l > 2'h1 ? 4'hf : c;
	endfunction
	function automatic pfs_pkg::pfs_state_t exp_st(logic [1:0] l);
		case (l)
			2'h0: return pfs_pkg::PFS_RUN;
			2'h1: return pfs_pkg::PFS_WARN;
			2'h2: return pfs_pkg::PFS_RESET;
			default: return pfs_pkg::PFS_BACKUP;
		endcase
	endfunction
	initial begin
		go(10);
		rst_n = 1;
		for (int i = 0; i < 60; i++) begin
			level = 2'($random(seed));
			go(5);
			core_ce_n = 4'($random(seed));
			core_rw_n = 1'($random(seed));
			go(1);
			chk("ce", exp_ce(level, core_ce_n), mem_ce_n);
			chk("rw", exp_ce(level, {3'h0, core_rw_n}) & 4'h1, mem_rw_n);
			chk("st", exp_st(level), state);
			chk("rst", level > 2'h1, core_reset);
			chk("bak", level == 2'h3, backup_select);
			chk("pd", level == 2'h3, core_power_down);
			chk("irq", 0, int_req);
			chk("vec", 8'h2b, int_vector);
		end
		level = 2'h0;
		warn_enable = 1;
		go(5);
		level = 2'h1;
		repeat (2) @(posedge clk);
		#1 chk("irq", 0, int_req);
		@(posedge clk);
		#1 chk("irq", 1, int_req);
		chk("rst", 0, core_reset);
		ack_en = 1;
		go(4);
		chk("irq", 0, int_req);
		go(6);
		chk("irq", 0, int_req);
		level = 2'h0;
		ack_en = 0;
		go(5);
		level = 2'h1;
		go(5);
		chk("irq", 1, int_req);
		level = 2'h2;
		go(5);
		chk("irq", 0, int_req);
		level = 2'h0;
		go(5);
		warn_enable = 0;
		level = 2'h1;
		go(5);
		chk("irq", 0, int_req);
		rst_n = 0;
		go(1);
		chk("rst", 1, core_reset);
		chk("ce", 4'hf, mem_ce_n);
		level = 2'h2;
		warn_enable = 1;
		go(1);
		rst_n = 1;
		go(1);
		chk("rst", 1, core_reset);
		go(7);
		chk("rst", 1, core_reset);
		chk("st", exp_st(level), state);
		level = 2'h1;
		go(5);
		chk("rst", 0, core_reset);
		chk("irq", 0, int_req);
		finish_test();
	end
	initial begin
		#20000;
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
